// [gbss_top.sv]
`timescale 1ns/1ns
// Start-up sequencer: self-test, initial command window, pause and program launch.
module gbss_top #(
  parameter int P_TICK_CYCLES = gbss_pkg::TICK_CYCLES,
  parameter int P_WAIT_TICKS = gbss_pkg::WAIT_TICKS,
  parameter int P_STRETCH_TICKS = gbss_pkg::STRETCH_TICKS
) (
  // Clock and power-on reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Management commands, one-cycle pulses
  input wire logic i_cmd_restart,
  input wire logic i_cmd_reset,
  input wire logic i_cmd_launch,
  input wire logic i_cmd_hold,
  input wire logic i_rec_valid,
  // Management answers
  output logic o_rec_accept,
  output logic o_rec_refused,
  // Pins from the board
  input wire logic i_remote_boot_sw,
  input wire logic i_pwr_restart,
  // Self-test engine
  output logic o_test_start,
  output logic [2:0] o_test_step,
  output logic o_mem_protect,
  input wire logic i_test_done,
  input wire logic i_test_pass,
  // Battery-backed configuration store
  input wire logic i_cfg_paused,
  input wire logic i_prog_valid,
  output logic o_clear_req,
  input wire logic i_clear_done,
  output logic o_cfg_pause_wr,
  output logic o_cfg_pause_val,
  // Network traffic, one-cycle pulses per packet
  input wire logic [1:0] i_traffic,
  // Status and indicators
  output logic o_led_power,
  output logic [1:0] o_led_traffic,
  output logic o_fatal,
  output logic o_window,
  output logic o_paused,
  output logic o_run_download,
  output logic o_run_builtin
);

  localparam int SW = $clog2(P_STRETCH_TICKS + 1);

  generate
    if (P_STRETCH_TICKS < 1) begin : g_bad
      $error("gbss_top: stretch count must be at least one");
    end
  endgenerate

  gbss_timer_if tif ();

  gbss_timer #(
    .P_TICK_CYCLES(P_TICK_CYCLES),
    .P_WAIT_TICKS(P_WAIT_TICKS)
  ) u_timer (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .tif(tif)
  );

  // Three-stage pin synchronisers; a level changes once stages two and three agree.
  logic [1:0] pin_raw;
  logic [1:0] pin_s1_reg;
  logic [1:0] pin_s2_reg;
  logic [1:0] pin_s3_reg;
  logic [1:0] pin_lvl_reg;
  logic pwr_restart_prev_reg;

  assign pin_raw = {i_pwr_restart, i_remote_boot_sw};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          pin_s1_reg[gi] <= 1'b0;
          pin_s2_reg[gi] <= 1'b0;
          pin_s3_reg[gi] <= 1'b0;
          pin_lvl_reg[gi] <= 1'b0;
        end else begin
          pin_s1_reg[gi] <= pin_raw[gi];
          pin_s2_reg[gi] <= pin_s1_reg[gi];
          pin_s3_reg[gi] <= pin_s2_reg[gi];
          if (pin_s2_reg[gi] == pin_s3_reg[gi]) begin
            pin_lvl_reg[gi] <= pin_s3_reg[gi];
          end
        end
      end
    end
  endgenerate

  logic remote_boot;
  logic pwr_restart_evt;

  assign remote_boot = pin_lvl_reg[0];
  assign pwr_restart_evt = pin_lvl_reg[1] && !pwr_restart_prev_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pwr_restart_prev_reg <= 1'b0;
    end else begin
      pwr_restart_prev_reg <= pin_lvl_reg[1];
    end
  end

  // Sequencer state.
  gbss_pkg::gbss_state_type state_reg;
  gbss_pkg::gbss_state_type state_next;
  logic test_busy_reg;
  logic clear_busy_reg;
  logic paused_reg;
  logic fatal_reg;
  logic [1:0] port_fail_reg;

  logic in_selftest;
  logic in_window;
  logic restart_any;
  logic step_done;

  function automatic logic is_test_state(input gbss_pkg::gbss_state_type s);
    return s == gbss_pkg::ST_LEDS_ON || s == gbss_pkg::ST_STACK
        || s == gbss_pkg::ST_BUFMEM || s == gbss_pkg::ST_PORT0
        || s == gbss_pkg::ST_PORT1;
  endfunction : is_test_state

  assign in_selftest = is_test_state(state_reg) || state_reg == gbss_pkg::ST_PWR_OFF
      || state_reg == gbss_pkg::ST_PWR_ON;
  assign in_window = state_reg == gbss_pkg::ST_WAIT || state_reg == gbss_pkg::ST_PAUSED;
  assign restart_any = i_cmd_restart || pwr_restart_evt;
  assign step_done = test_busy_reg && i_test_done;

  // Launch decision shared by the launch command and the timeout.
  function automatic gbss_pkg::gbss_state_type launch_target(input logic valid,
      input logic sw, input logic from_cmd);
    if (valid) begin
      return gbss_pkg::ST_RUN_DL;
    end else if (from_cmd && sw) begin
      return gbss_pkg::ST_INIT;
    end
    return gbss_pkg::ST_RUN_ROM;
  endfunction : launch_target

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      gbss_pkg::ST_LEDS_ON: begin
        if (step_done) begin
          state_next = i_test_pass ? gbss_pkg::ST_PWR_OFF : gbss_pkg::ST_FATAL;
        end
      end
      gbss_pkg::ST_PWR_OFF: begin
        state_next = gbss_pkg::ST_STACK;
      end
      gbss_pkg::ST_STACK: begin
        if (step_done) begin
          state_next = i_test_pass ? gbss_pkg::ST_BUFMEM : gbss_pkg::ST_FATAL;
        end
      end
      gbss_pkg::ST_BUFMEM: begin
        if (step_done) begin
          state_next = i_test_pass ? gbss_pkg::ST_PORT0 : gbss_pkg::ST_FATAL;
        end
      end
      gbss_pkg::ST_PORT0: begin
        if (step_done) begin
          state_next = gbss_pkg::ST_PORT1;
        end
      end
      gbss_pkg::ST_PORT1: begin
        if (step_done) begin
          state_next = gbss_pkg::ST_PWR_ON;
        end
      end
      gbss_pkg::ST_PWR_ON: begin
        state_next = gbss_pkg::ST_INIT;
      end
      gbss_pkg::ST_FATAL: begin
        state_next = gbss_pkg::ST_FATAL;
      end
      gbss_pkg::ST_CLEAR: begin
        if (clear_busy_reg && i_clear_done) begin
          state_next = gbss_pkg::ST_INIT;
        end
      end
      gbss_pkg::ST_INIT: begin
        state_next = i_cfg_paused ? gbss_pkg::ST_PAUSED : gbss_pkg::ST_WAIT;
      end
      gbss_pkg::ST_WAIT, gbss_pkg::ST_PAUSED: begin
        if (i_cmd_launch) begin
          state_next = launch_target(i_prog_valid, remote_boot, 1'b1);
        end else if (i_cmd_hold) begin
          state_next = gbss_pkg::ST_PAUSED;
        end else if (state_reg == gbss_pkg::ST_WAIT && !i_rec_valid && tif.expired) begin
          state_next = launch_target(i_prog_valid, remote_boot, 1'b0);
        end
      end
      gbss_pkg::ST_RUN_DL, gbss_pkg::ST_RUN_ROM: begin
        state_next = state_reg;
      end
      default: begin
        state_next = gbss_pkg::ST_FATAL;
      end
    endcase
    // Management commands outside self-test and the fatal state override the step above.
    if (!in_selftest && state_reg != gbss_pkg::ST_FATAL) begin
      if (i_cmd_reset) begin
        state_next = gbss_pkg::ST_CLEAR;
      end else if (restart_any && state_reg != gbss_pkg::ST_CLEAR) begin
        state_next = gbss_pkg::ST_INIT;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg <= gbss_pkg::ST_LEDS_ON;
    end else begin
      state_reg <= state_next;
    end
  end

  // Self-test engine handshake: one start pulse per step, then wait for done.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      test_busy_reg <= 1'b0;
      o_test_start <= 1'b0;
      o_test_step <= gbss_pkg::STEP_LEDS;
    end else begin
      o_test_start <= 1'b0;
      if (step_done) begin
        test_busy_reg <= 1'b0;
      end else if (is_test_state(state_reg) && !test_busy_reg && state_next == state_reg) begin
        test_busy_reg <= 1'b1;
        o_test_start <= 1'b1;
        case (state_reg)
          gbss_pkg::ST_STACK: o_test_step <= gbss_pkg::STEP_STACK;
          gbss_pkg::ST_BUFMEM: o_test_step <= gbss_pkg::STEP_BUFMEM;
          gbss_pkg::ST_PORT0: o_test_step <= gbss_pkg::STEP_PORT0;
          gbss_pkg::ST_PORT1: o_test_step <= gbss_pkg::STEP_PORT1;
          default: o_test_step <= gbss_pkg::STEP_LEDS;
        endcase
      end
    end
  end

  // Protected regions stay write-locked throughout self-test.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_mem_protect <= 1'b1;
    end else begin
      o_mem_protect <= state_next != gbss_pkg::ST_CLEAR;
    end
  end

  // Memory clear on reset command.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      clear_busy_reg <= 1'b0;
      o_clear_req <= 1'b0;
    end else begin
      o_clear_req <= 1'b0;
      if (state_reg == gbss_pkg::ST_CLEAR && i_clear_done && clear_busy_reg) begin
        clear_busy_reg <= 1'b0;
      end else if (state_next == gbss_pkg::ST_CLEAR && state_reg != gbss_pkg::ST_CLEAR) begin
        clear_busy_reg <= 1'b1;
        o_clear_req <= 1'b1;
      end
    end
  end

  // Pause flag and its copy in the stored configuration.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      paused_reg <= 1'b0;
      o_cfg_pause_wr <= 1'b0;
      o_cfg_pause_val <= 1'b0;
    end else begin
      o_cfg_pause_wr <= 1'b0;
      if (state_next == gbss_pkg::ST_CLEAR && state_reg != gbss_pkg::ST_CLEAR) begin
        paused_reg <= 1'b0;
        o_cfg_pause_wr <= 1'b1;
        o_cfg_pause_val <= 1'b0;
      end else if (state_reg == gbss_pkg::ST_INIT) begin
        paused_reg <= i_cfg_paused;
      end else if (in_window && i_cmd_launch && !restart_any && !i_cmd_reset) begin
        paused_reg <= 1'b0;
        o_cfg_pause_wr <= 1'b1;
        o_cfg_pause_val <= 1'b0;
      end else if (state_next == gbss_pkg::ST_PAUSED && state_reg == gbss_pkg::ST_WAIT) begin
        paused_reg <= 1'b1;
        o_cfg_pause_wr <= 1'b1;
        o_cfg_pause_val <= 1'b1;
      end
    end
  end

  // Download records and wait-window reload.
  logic rec_take;

  assign rec_take = i_rec_valid && in_window && state_next == state_reg;
  assign tif.reload = state_reg == gbss_pkg::ST_INIT || rec_take;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_rec_accept <= 1'b0;
      o_rec_refused <= 1'b0;
    end else begin
      o_rec_accept <= rec_take;
      o_rec_refused <= i_rec_valid && !rec_take;
    end
  end

  // Self-test results for the two traffic LEDs.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      port_fail_reg <= 2'b11;
      fatal_reg <= 1'b0;
    end else begin
      if (state_reg == gbss_pkg::ST_PORT0 && step_done && i_test_pass) begin
        port_fail_reg[0] <= 1'b0;
      end
      if (state_reg == gbss_pkg::ST_PORT1 && step_done && i_test_pass) begin
        port_fail_reg[1] <= 1'b0;
      end
      if (state_next == gbss_pkg::ST_FATAL) begin
        fatal_reg <= 1'b1;
      end
    end
  end

  // Traffic pulse stretchers, one per port.
  logic [1:0] stretch_on;

  generate
    for (gi = 0; gi < 2; gi++) begin : g_stretch
      logic [SW-1:0] cnt_reg;
      always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
          cnt_reg <= '0;
        end else if (i_traffic[gi]) begin
          cnt_reg <= SW'(P_STRETCH_TICKS);
        end else if (tif.tick && cnt_reg != '0) begin
          cnt_reg <= cnt_reg - SW'(1);
        end
      end
      assign stretch_on[gi] = cnt_reg != '0;
    end
  endgenerate

  // Indicator drive.
  logic running;

  assign running = !in_selftest && !fatal_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_led_power <= 1'b1;
      o_led_traffic <= 2'b00;
    end else begin
      if (state_reg == gbss_pkg::ST_LEDS_ON) begin
        o_led_power <= 1'b1;
        o_led_traffic <= 2'b11;
      end else if (state_reg == gbss_pkg::ST_PWR_OFF || fatal_reg) begin
        o_led_power <= 1'b0;
        o_led_traffic <= fatal_reg ? 2'b11 : port_fail_reg;
      end else if (state_reg == gbss_pkg::ST_PWR_ON || running) begin
        o_led_power <= 1'b1;
        o_led_traffic <= port_fail_reg | (running ? stretch_on : 2'b00);
      end else begin
        o_led_traffic <= port_fail_reg;
      end
    end
  end

  // Status outputs.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_fatal <= 1'b0;
      o_window <= 1'b0;
      o_paused <= 1'b0;
      o_run_download <= 1'b0;
      o_run_builtin <= 1'b0;
    end else begin
      o_fatal <= fatal_reg;
      o_window <= state_next == gbss_pkg::ST_WAIT || state_next == gbss_pkg::ST_PAUSED;
      o_paused <= state_next == gbss_pkg::ST_PAUSED;
      o_run_download <= state_next == gbss_pkg::ST_RUN_DL;
      o_run_builtin <= state_next == gbss_pkg::ST_RUN_ROM;
    end
  end

endmodule : gbss_top

// [gbss_pkg.sv]
// How it works
// - Power-on, restart or reset command all end in the initial waiting state.
// - A reset command clears configuration and downloaded program before the initial state.
// - Restart keeps program and configuration; reset clears all; both reach the initial state.
// - The initial state waits 25 seconds for a command before leaving alone.
// - On timeout, not paused: run a valid download, otherwise run the built-in program.
// - Download records are taken only in the window or paused, refused once running.
// - Every accepted download record restarts the wait timer.
// - A launch command checks the download at once and runs it when valid.
// - Launch with invalid download: built-in program if boot switch off, else restart.
// - A hold command in the window pauses; paused waits forever for commands.
// - Only a launch or a reset command clears the paused state.
// - The paused state survives restart and power cycle.
// - The pause flag is written into the stored configuration data.
// - First self-test step lights all three LEDs; failure there is fatal.
// - Second step turns the power LED off until self-test ends, off on fatal.
// - Stack memory check; on failure all remaining steps are skipped.
// - Memory test touches only unprotected buffer memory, never protected regions.
// - First controller passes its test: middle LED goes off.
// - Ethernet controller partly initialised and tested: rightmost LED off on pass.
// - Without fatal error the power LED comes back on to end self-test.
// - A traffic LED left lit marks its port dead; both lit means fatal or both dead.
// - In operation each traffic LED lights for packets on its own port.
package gbss_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int TICK_TIME_NS = 1_000_000;
  localparam int TICK_CYCLES = (TICK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_TIME_S = 25;
  localparam int WAIT_TICKS = WAIT_TIME_S * (1_000_000_000 / TICK_TIME_NS);
  localparam int STRETCH_TIME_MS = 2;
  localparam int STRETCH_TICKS = STRETCH_TIME_MS * 1_000_000 / TICK_TIME_NS;

  // Self-test step codes shown to the test engine.
  localparam logic [2:0] STEP_LEDS = 3'h0;
  localparam logic [2:0] STEP_STACK = 3'h1;
  localparam logic [2:0] STEP_BUFMEM = 3'h2;
  localparam logic [2:0] STEP_PORT0 = 3'h3;
  localparam logic [2:0] STEP_PORT1 = 3'h4;

  typedef enum logic [3:0] {
    ST_LEDS_ON,
    ST_PWR_OFF,
    ST_STACK,
    ST_BUFMEM,
    ST_PORT0,
    ST_PORT1,
    ST_PWR_ON,
    ST_FATAL,
    ST_CLEAR,
    ST_INIT,
    ST_WAIT,
    ST_PAUSED,
    ST_RUN_DL,
    ST_RUN_ROM
  } gbss_state_type;

endpackage : gbss_pkg

// [gbss_timer_if.sv]
`timescale 1ns/1ns
interface gbss_timer_if;
  logic reload;
  logic tick;
  logic expired;

  modport ctrl (output reload, input tick, input expired);
  modport timer (input reload, output tick, output expired);
endinterface : gbss_timer_if

// [gbss_timer.sv]
`timescale 1ns/1ns
// Prescaled wait-window counter: a 1 ms enable pulse and a countdown of ticks.
module gbss_timer #(
  parameter int P_TICK_CYCLES = gbss_pkg::TICK_CYCLES,
  parameter int P_WAIT_TICKS = gbss_pkg::WAIT_TICKS
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Controller side
  gbss_timer_if.timer tif
);

  localparam int PW = $clog2(P_TICK_CYCLES + 1);
  localparam int WW = $clog2(P_WAIT_TICKS + 1);

  generate
    if (P_TICK_CYCLES < 1 || P_WAIT_TICKS < 1) begin : g_bad
      $error("gbss_timer: counts must be at least one");
    end
  endgenerate

  logic [PW-1:0] pre_reg;
  logic [WW-1:0] wait_reg;
  logic tick_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      pre_reg <= '0;
      tick_reg <= 1'b0;
    end else if (pre_reg == PW'(P_TICK_CYCLES - 1)) begin
      pre_reg <= '0;
      tick_reg <= 1'b1;
    end else begin
      pre_reg <= pre_reg + PW'(1);
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      wait_reg <= '0;
    end else if (tif.reload) begin
      wait_reg <= WW'(P_WAIT_TICKS);
    end else if (tick_reg && wait_reg != '0) begin
      wait_reg <= wait_reg - WW'(1);
    end
  end

  assign tif.tick = tick_reg;
  assign tif.expired = (wait_reg == '0) && !tif.reload;

endmodule : gbss_timer

// [gbss_top_sva.sv]
`timescale 1ns/1ns
module gbss_top_sva #(
  parameter int P_TICK_CYCLES = gbss_pkg::TICK_CYCLES,
  parameter int P_WAIT_TICKS = gbss_pkg::WAIT_TICKS,
  parameter int P_STRETCH_TICKS = gbss_pkg::STRETCH_TICKS
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_srst,
  // Commands and pins
  input wire logic i_cmd_restart,
  input wire logic i_cmd_reset,
  input wire logic i_cmd_launch,
  input wire logic i_cmd_hold,
  input wire logic i_rec_valid,
  input wire logic i_remote_boot_sw,
  input wire logic i_prog_valid,
  // Outputs watched
  input wire logic o_rec_accept,
  input wire logic o_rec_refused,
  input wire logic o_test_start,
  input wire logic [2:0] o_test_step,
  input wire logic o_mem_protect,
  input wire logic o_clear_req,
  input wire logic o_cfg_pause_wr,
  input wire logic o_cfg_pause_val,
  input wire logic o_led_power,
  input wire logic [1:0] o_led_traffic,
  input wire logic o_fatal,
  input wire logic o_window,
  input wire logic o_paused,
  input wire logic o_run_download,
  input wire logic o_run_builtin
);
  localparam int WIN_MAX = P_TICK_CYCLES * P_WAIT_TICKS + 2 * P_TICK_CYCLES + 4;
  int win_cnt;
  wire cmd_hi = i_cmd_reset | i_cmd_restart;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_srst);
  // Counts quiet cycles in the unpaused window.
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !o_window || o_paused || i_rec_valid || cmd_hi) begin
      win_cnt <= 0;
    end else begin
      win_cnt <= win_cnt + 1;
    end
  end
  AST_WIN_MAX: assert property (win_cnt <= WIN_MAX)
    else $error("wait window outlasted its count");
  AST_REC_ACC: assert property ((o_window || o_paused) && i_rec_valid && !i_cmd_launch
    && !i_cmd_hold && !cmd_hi |=> o_rec_accept) else $error("record in window not accepted");
  AST_REC_REF: assert property (i_rec_valid && (o_run_download || o_run_builtin)
    |=> o_rec_refused && !o_rec_accept) else $error("record taken while running");
  AST_LAUNCH_DL: assert property (o_window && i_cmd_launch && i_prog_valid && !cmd_hi
    |=> o_run_download) else $error("valid program not launched");
  AST_LAUNCH_ROM: assert property ((!i_remote_boot_sw) [*5] ##0 (o_window && i_cmd_launch
    && !i_prog_valid && !cmd_hi) |=> o_run_builtin) else $error("built-in program not run");
  AST_LAUNCH_RST: assert property (i_remote_boot_sw [*5] ##0 (o_window && i_cmd_launch
    && !i_prog_valid && !cmd_hi) |=> (!o_run_builtin && !o_run_download) ##[0:2] o_window)
    else $error("invalid launch with switch on did not restart");
  AST_HOLD: assert property (o_window && !o_paused && i_cmd_hold && !i_cmd_launch && !cmd_hi
    |=> o_paused && o_cfg_pause_wr && o_cfg_pause_val) else $error("hold did not pause");
  AST_PAUSE_KEEP: assert property (o_paused && !i_cmd_launch && !cmd_hi |=> o_paused)
    else $error("paused state left without launch or reset");
  AST_RESET_CLR: assert property (o_window && i_cmd_reset |=> ##[0:1] o_clear_req)
    else $error("reset did not request a clear");
  AST_PROTECT: assert property (o_test_start |-> o_mem_protect)
    else $error("self-test step with regions unprotected");
  AST_LEDS_ON: assert property (o_test_start && o_test_step == gbss_pkg::STEP_LEDS
    |-> o_led_power && o_led_traffic == 2'b11) else $error("first step without all LEDs lit");
  AST_PWR_OFF: assert property (o_test_start && o_test_step != gbss_pkg::STEP_LEDS
    |-> !o_led_power) else $error("power LED lit during self-test");
  AST_FATAL: assert property (o_fatal |-> !o_led_power && o_led_traffic == 2'b11)
    else $error("fatal indication wrong");
  COV_PAUSED: cover property (o_paused);
  COV_DL: cover property (o_run_download);
  COV_ROM: cover property (o_run_builtin);
  COV_FATAL: cover property (o_fatal);
endmodule : gbss_top_sva
bind gbss_top gbss_top_sva #(.P_TICK_CYCLES(P_TICK_CYCLES), .P_WAIT_TICKS(P_WAIT_TICKS),
  .P_STRETCH_TICKS(P_STRETCH_TICKS)) i_sva (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
  .i_cmd_restart(i_cmd_restart), .i_cmd_reset(i_cmd_reset), .i_cmd_launch(i_cmd_launch),
  .i_cmd_hold(i_cmd_hold), .i_rec_valid(i_rec_valid), .i_remote_boot_sw(i_remote_boot_sw),
  .i_prog_valid(i_prog_valid), .o_rec_accept(o_rec_accept), .o_rec_refused(o_rec_refused),
  .o_test_start(o_test_start), .o_test_step(o_test_step), .o_mem_protect(o_mem_protect),
  .o_clear_req(o_clear_req), .o_cfg_pause_wr(o_cfg_pause_wr), .o_cfg_pause_val(o_cfg_pause_val),
  .o_led_power(o_led_power), .o_led_traffic(o_led_traffic), .o_fatal(o_fatal),
  .o_window(o_window), .o_paused(o_paused), .o_run_download(o_run_download),
  .o_run_builtin(o_run_builtin));

// [gbss_far_model.sv]
`timescale 1ns/1ns
// Self-test engine and battery-backed store; the store survives i_srst.
module gbss_far_model (
  // Clock
  input wire logic i_clk_sys,
  // Requests from the sequencer
  input wire logic i_test_start,
  input wire logic [2:0] i_test_step,
  input wire logic i_clear_req,
  input wire logic i_pause_wr,
  input wire logic i_pause_val,
  // Bench controls
  input wire logic [3:0] i_fail_step,
  input wire logic i_prog_load,
  input wire logic i_slow,
  // Answers
  output logic o_test_done = 1'b0,
  output logic o_test_pass = 1'b0,
  output logic o_clear_done = 1'b0,
  output logic o_cfg_paused = 1'b0,
  output logic o_prog_valid = 1'b0
);
  logic [3:0] t_cnt = 4'h0;
  logic [2:0] step_reg = 3'h0;
  logic [1:0] c_cnt = 2'h0;
  always @(posedge i_clk_sys) begin
    o_test_done <= 1'b0;
    o_test_pass <= ~o_test_pass;
    if (i_test_start) begin
      t_cnt <= i_slow ? 4'h9 : 4'h2;
      step_reg <= i_test_step;
    end else if (t_cnt != 4'h0) begin
      t_cnt <= t_cnt - 4'h1;
      if (t_cnt == 4'h1) begin
        o_test_done <= 1'b1;
        o_test_pass <= {1'b0, step_reg} != i_fail_step;
      end
    end
  end
  always @(posedge i_clk_sys) begin
    o_clear_done <= c_cnt == 2'h1;
    if (i_clear_req) begin
      c_cnt <= 2'h3;
      o_prog_valid <= 1'b0;
      o_cfg_paused <= 1'b0;
    end else begin
      c_cnt <= (c_cnt != 2'h0) ? c_cnt - 2'h1 : 2'h0;
      if (i_pause_wr) o_cfg_paused <= i_pause_val;
      if (i_prog_load) o_prog_valid <= 1'b1;
    end
  end
endmodule : gbss_far_model

// [test_gateway_boot_selftest_sequencer.sv]
`timescale 1ns/1ns
module test_gateway_boot_selftest_sequencer;
  logic i_clk_sys = 1'b0;
  logic i_srst = 1'b1;
  logic restart = 0, reset = 0, launch = 0, hold = 0, rec = 0, sw = 0, load = 0, slow = 0;
  logic [3:0] fail_step = 4'hf;
  logic [1:0] traffic = 2'b00;
  logic rec_acc, rec_ref, t_start, mem_prot, t_done, t_pass, cfg_p, prog_v;
  logic clr_req, clr_done, p_wr, p_val, led_pwr, fatal, window, paused, run_dl, run_rom;
  logic [2:0] t_step;
  logic [1:0] led_tr;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  wire [5:0] watch = {fatal, run_rom, run_dl, paused, window | paused, clr_req};
  gbss_top #(.P_TICK_CYCLES(4), .P_WAIT_TICKS(20), .P_STRETCH_TICKS(2)) i_dut (
    .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_cmd_restart(restart), .i_cmd_reset(reset),
    .i_cmd_launch(launch), .i_cmd_hold(hold), .i_rec_valid(rec), .o_rec_accept(rec_acc),
    .o_rec_refused(rec_ref), .i_remote_boot_sw(sw), .i_pwr_restart(1'b0),
    .o_test_start(t_start), .o_test_step(t_step), .o_mem_protect(mem_prot),
    .i_test_done(t_done), .i_test_pass(t_pass), .i_cfg_paused(cfg_p), .i_prog_valid(prog_v),
    .o_clear_req(clr_req), .i_clear_done(clr_done), .o_cfg_pause_wr(p_wr),
    .o_cfg_pause_val(p_val), .i_traffic(traffic), .o_led_power(led_pwr),
    .o_led_traffic(led_tr), .o_fatal(fatal), .o_window(window), .o_paused(paused),
    .o_run_download(run_dl), .o_run_builtin(run_rom));
  gbss_far_model i_far (.i_clk_sys(i_clk_sys), .i_test_start(t_start), .i_test_step(t_step),
    .i_clear_req(clr_req), .i_pause_wr(p_wr), .i_pause_val(p_val), .i_fail_step(fail_step),
    .i_prog_load(load), .i_slow(slow), .o_test_done(t_done), .o_test_pass(t_pass),
    .o_clear_done(clr_done), .o_cfg_paused(cfg_p), .o_prog_valid(prog_v));
  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_sim
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic wait_bit(input int b, input logic st, input logic [2:0] step);
    int n;
    n = 0;
    while ((st ? !(t_start === 1'b1 && t_step === step) : watch[b] !== 1'b1) && n < 400) begin
      cyc(1);
      n++;
    end
    if (n == 400) begin
      mismatches++;
      $display("[ERR] wait %0d expected 1 seen 0", b);
    end
  endtask : wait_bit
  task automatic do_reset;
    i_srst = 1'b1;
    cyc(20);
    i_srst = 1'b0;
  endtask : do_reset
  task automatic t_selftest(input logic f);
    do_reset();
    wait_bit(0, 1, gbss_pkg::STEP_LEDS);
    chk("leds first step", {led_pwr, led_tr}, 3'b111);
    wait_bit(0, 1, gbss_pkg::STEP_STACK);
    chk("power led in test", led_pwr, 1'b0);
    wait_bit(0, 1, gbss_pkg::STEP_PORT1);
    chk("middle led", led_tr[0], f);
    wait_bit(1, 0, 3'h0);
    chk("leds after test", {led_pwr, led_tr}, {2'b10, f});
    chk("window", window, 1'b1);
  endtask : t_selftest
  task automatic t_timeout;
    int n;
    n = 0;
    while (run_rom !== 1'b1 && n < 200) begin
      cyc(1);
      n++;
    end
    chk("window length", n >= 76 && n <= 96, 1'b1);
    pulse(rec);
    chk("late record", {rec_ref, rec_acc}, 2'b10);
    traffic = 2'b01;
    cyc(1);
    traffic = 2'b00;
    cyc(2);
    chk("traffic led", led_tr, 2'b01);
    cyc(30);
    chk("traffic led idle", led_tr, 2'b00);
  endtask : t_timeout
  task automatic t_reload_pause;
    pulse(restart);
    wait_bit(1, 0, 3'h0);
    chk("restart window", {window, run_rom}, 2'b10);
    cyc(60);
    pulse(rec);
    chk("record taken", rec_acc, 1'b1);
    cyc(60);
    chk("window kept", window, 1'b1);
    pulse(hold);
    cyc(1);
    chk("paused", {paused, cfg_p}, 2'b11);
    cyc(150);
    chk("still paused", paused, 1'b1);
    pulse(restart);
    cyc(3);
    wait_bit(2, 0, 3'h0);
    chk("paused after restart", {paused, run_rom}, 2'b10);
  endtask : t_reload_pause
  task automatic t_power_launch;
    t_selftest(0);
    cyc(3);
    chk("paused after power cycle", paused, 1'b1);
    pulse(load);
    pulse(launch);
    cyc(1);
    chk("download runs", {run_dl, paused, cfg_p}, 3'b100);
  endtask : t_power_launch
  task automatic t_reset_launch;
    pulse(reset);
    wait_bit(0, 0, 3'h0);
    wait_bit(1, 0, 3'h0);
    chk("store cleared", {prog_v, cfg_p, paused}, 3'b000);
    sw = 1'b1;
    cyc(6);
    pulse(launch);
    cyc(1);
    wait_bit(1, 0, 3'h0);
    chk("switch on launch", {run_rom, run_dl}, 2'b00);
    sw = 1'b0;
    cyc(6);
    pulse(launch);
    cyc(1);
    chk("switch off launch", run_rom, 1'b1);
  endtask : t_reset_launch
  task automatic t_port_fail;
    fail_step = 4'h3;
    slow = 1'b1;
    t_selftest(1);
    chk("dead port led", {fatal, led_tr}, 3'b001);
  endtask : t_port_fail
  task automatic t_fatal;
    int n;
    n = 0;
    fail_step = 4'h1;
    slow = 1'b0;
    do_reset();
    wait_bit(5, 0, 3'h0);
    chk("fatal leds", {led_pwr, led_tr}, 3'b011);
    repeat (40) begin
      cyc(1);
      n += int'(t_start === 1'b1);
    end
    chk("steps after fatal", {n != 0, window}, 2'b00);
  endtask : t_fatal
  initial begin
    t_selftest(0);
    t_timeout();
    t_reload_pause();
    t_power_launch();
    t_reset_launch();
    t_port_fail();
    t_fatal();
    end_sim();
  end
endmodule : test_gateway_boot_selftest_sequencer
